//--- design/dtp_pkg.sv
// Constants, register map and carrier types for the down-count timer/PWM.
// Notes on behaviour
// - Sixteen-bit counter only ever counts down.
// - Counting clock chosen from several sources.
// - Compare output follows configured compare condition.
// - Period reloads on start, reset, terminal count.
// - Reset input restarts; capture input latches count.
// - Capture stores full sixteen-bit count value.
// - Interrupt on terminal count, compare, capture.
// - Free-running, one-shot or enable-gated modes.
// - One-shot stops at period end until restart.
// - Enable mode counts only while enable held.
// - Compare, complement, terminal-count and interrupt outputs.
// - Complementary outputs separated by deadband.
// - Kill input overrides the compare and complement outputs.
package dtp_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_PERIOD  = 8'h04;
	localparam logic [7:0] ADDR_COMPARE = 8'h08;
	localparam logic [7:0] ADDR_COUNT   = 8'h0C;
	localparam logic [7:0] ADDR_CAPTURE = 8'h10;
	localparam logic [7:0] ADDR_STATUS  = 8'h14;
	localparam logic [7:0] ADDR_MASK    = 8'h18;
	localparam logic [7:0] ADDR_DEAD    = 8'h1C;

	// ****************************************
	// Control field positions
	// ****************************************
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_START  = 1;
	localparam int CTRL_MODE_L = 2;
	localparam int CTRL_CMP_L  = 4;
	localparam int CTRL_CLK_L  = 7;

	localparam int ST_TC  = 0;
	localparam int ST_CMP = 1;
	localparam int ST_CAP = 2;

	localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
	localparam logic [15:0] RST_COMPARE = 16'h8000;
	localparam logic [7:0]  RST_DEAD    = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_FREE   = 2'b00,
		MODE_ONE    = 2'b01,
		MODE_ENABLE = 2'b10
	} dtp_mode_e;

	typedef enum logic [2:0] {
		cmp_less          = 3'b000,
		cmp_less_equal    = 3'b001,
		cmp_equal         = 3'b010,
		cmp_greater_equal = 3'b011,
		cmp_greater       = 3'b100
	} dtp_cmp_e;

	typedef struct packed {
		logic trig;
		logic reset;
		logic capture;
		logic enable;
		logic kill;
	} dtp_ctl_in_s;

	typedef struct packed {
		logic cmp;
		logic cmp_n;
		logic tc;
	} dtp_pwm_out_s;

endpackage

//--- design/dtp_timer.sv
// Down-count timer, counter and PWM with an AXI4-Lite register slave.
`timescale 1ns/100ps
module dtp_timer #(
	parameter int NCLK = 4
) (
	// Clock and reset.
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// Routed control inputs and clock sources.
	input  wire dtp_pkg::dtp_ctl_in_s  i_ctl,
	input  wire logic [NCLK-1:0]       i_clk_src,
	// Routed outputs.
	output dtp_pkg::dtp_pwm_out_s      o_pwm,
	output logic                       o_irq,
	// AXI4-Lite write channels.
	input  wire logic [7:0]            i_awaddr,
	input  wire logic                  i_awvalid,
	output logic                       o_awready,
	input  wire logic [31:0]           i_wdata,
	input  wire logic [3:0]            i_wstrb,
	input  wire logic                  i_wvalid,
	output logic                       o_wready,
	output logic [1:0]                 o_bresp,
	output logic                       o_bvalid,
	input  wire logic                  i_bready,
	// AXI4-Lite read channels.
	input  wire logic [7:0]            i_araddr,
	input  wire logic                  i_arvalid,
	output logic                       o_arready,
	output logic [31:0]                o_rdata,
	output logic [1:0]                 o_rresp,
	output logic                       o_rvalid,
	input  wire logic                  i_rready
);
	import dtp_pkg::*;

	if (NCLK < 1 || NCLK > 8) begin
		$error("NCLK must be 1 to 8");
	end

	function automatic logic cmp_true(input logic [2:0] c,
		input logic [15:0] a, input logic [15:0] b);
		case (c)
			cmp_less:          cmp_true = a < b;
			cmp_less_equal:    cmp_true = a <= b;
			cmp_equal:         cmp_true = a == b;
			cmp_greater_equal: cmp_true = a >= b;
			cmp_greater:       cmp_true = a > b;
			default:           cmp_true = 1'b0;
		endcase
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [9:0]  ctrl;
	logic [15:0] period;
	logic [15:0] compare;
	logic [15:0] count;
	logic [15:0] capture;
	logic [2:0]  status;
	logic [2:0]  mask;
	logic [7:0]  dead;
	logic        running;
	logic        src_q;
	logic        cmp_q;
	logic        cap_q;
	logic        rst_q;
	logic        trig_q;
	logic [7:0]  dead_cnt;
	logic        raw_q;

	// ****************************************
	// Bus decode
	// ****************************************
	logic [7:0]  aw_a;
	logic [31:0] w_d;
	logic        aw_have;
	logic        w_have;
	wire         wr_go    = aw_have && w_have && !o_bvalid;
	wire         wr_ctrl  = wr_go && aw_a == ADDR_CTRL;
	wire         wr_per   = wr_go && aw_a == ADDR_PERIOD;
	wire         wr_cmpv  = wr_go && aw_a == ADDR_COMPARE;
	wire         wr_stat  = wr_go && aw_a == ADDR_STATUS;
	wire         wr_mask  = wr_go && aw_a == ADDR_MASK;
	wire         wr_dead  = wr_go && aw_a == ADDR_DEAD;
	wire         wr_ok    = wr_ctrl || wr_per || wr_cmpv || wr_stat
		|| wr_mask || wr_dead;
	wire         rd_go    = i_arvalid && o_arready;
	wire         rd_ok    = i_araddr <= ADDR_DEAD && i_araddr[1:0] == 2'b00;

	wire [2:0]   clk_sel  = ctrl[CTRL_CLK_L +: 3];
	wire [1:0]   mode     = ctrl[CTRL_MODE_L +: 2];
	wire [2:0]   cmp_sel  = ctrl[CTRL_CMP_L +: 3];
	// Clock sources are sampled; a rising edge on the selected one is a tick.
	// A select beyond the last source wraps round to a fitted one.
	wire         src_now  = i_clk_src[32'(clk_sel) % NCLK];
	wire         tick_raw = src_now && !src_q;
	wire         gate_ok  = mode != MODE_ENABLE || i_ctl.enable;
	wire         tick     = tick_raw && running && ctrl[CTRL_RUN] && gate_ok;
	wire         at_zero  = count == 16'h0000;
	wire         start_ev = (wr_ctrl && w_d[CTRL_START])
		|| (i_ctl.trig && !trig_q);
	wire         rst_ev   = i_ctl.reset && !rst_q;
	wire         cap_ev   = i_ctl.capture && !cap_q;
	wire         cmp_now  = cmp_true(cmp_sel, count, compare);
	wire         cmp_rise = cmp_now && !cmp_q;
	wire         tc_ev    = tick && at_zero;
	wire [2:0]   ev       = {cap_ev, cmp_rise, tc_ev};
	wire [15:0]  next_count = (start_ev || rst_ev || tc_ev) ? period
		: tick ? count - 16'h0001 : count;
	wire         next_running = (start_ev || rst_ev) ? 1'b1
		: (tc_ev && mode == MODE_ONE) ? 1'b0 : running;
	wire         raw_cmp  = cmp_now;
	// Deadband delays only the rising edge of each phase.
	// Lifting kill restores the phase at once, with no deadband of its own.
	wire         dead_done = dead_cnt == 8'h00;
	wire         next_cmp = !i_ctl.kill && raw_q && dead_done;
	wire         next_cmpn = !i_ctl.kill && !raw_q && dead_done;

	// ****************************************
	// Counter core
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count    <= 16'h0000;
			running  <= 1'b0;
			src_q    <= 1'b0;
			// Count zero lies below the reset compare value, so no rise
			// is reported for a comparison that was already true.
			cmp_q    <= 1'b1;
			cap_q    <= 1'b0;
			rst_q    <= 1'b0;
			trig_q   <= 1'b0;
			capture  <= 16'h0000;
			raw_q    <= 1'b0;
			dead_cnt <= 8'h00;
			o_pwm    <= '0;
		end else begin
			count   <= next_count;
			running <= next_running;
			src_q   <= src_now;
			cmp_q   <= cmp_now;
			cap_q   <= i_ctl.capture;
			rst_q   <= i_ctl.reset;
			trig_q  <= i_ctl.trig;
			if (cap_ev) begin
				capture <= count;
			end
			raw_q <= raw_cmp;
			if (raw_cmp != raw_q) begin
				dead_cnt <= dead;
			end else if (!dead_done) begin
				dead_cnt <= dead_cnt - 8'h01;
			end
			o_pwm.cmp   <= next_cmp;
			o_pwm.cmp_n <= next_cmpn;
			if (tc_ev) begin
				o_pwm.tc <= 1'b1;
			end else if (tick_raw) begin
				o_pwm.tc <= 1'b0;
			end
		end
	end

	// ****************************************
	// Register writes and interrupt
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl    <= '0;
			period  <= RST_PERIOD;
			compare <= RST_COMPARE;
			dead    <= RST_DEAD;
			mask    <= '0;
			status  <= '0;
			o_irq   <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl <= w_d[9:0] & ~(10'h001 << CTRL_START);
			if (wr_per) period <= w_d[15:0];
			if (wr_cmpv) compare <= w_d[15:0];
			if (wr_dead) dead <= w_d[7:0];
			if (wr_mask) mask <= w_d[2:0];
			// A new event wins over a clear in the same cycle.
			status <= (status & ~(wr_stat ? w_d[2:0] : 3'b000)) | ev;
			o_irq  <= |(status & mask);
		end
	end

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aw_have   <= 1'b0;
			w_have    <= 1'b0;
			aw_a      <= '0;
			w_d       <= '0;
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= '0;
			o_rresp   <= RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_a      <= i_awaddr;
				aw_have   <= 1'b1;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_d      <= i_wdata;
				w_have   <= 1'b1;
				o_wready <= 1'b0;
			end
			if (wr_go) begin
				o_bvalid <= 1'b1;
				o_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
				aw_have  <= 1'b0;
				w_have   <= 1'b0;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
			if (rd_go) begin
				o_arready <= 1'b0;
				o_rvalid  <= 1'b1;
				o_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
				case (i_araddr)
					ADDR_CTRL:    o_rdata <= {22'h0, ctrl};
					ADDR_PERIOD:  o_rdata <= {16'h0, period};
					ADDR_COMPARE: o_rdata <= {16'h0, compare};
					ADDR_COUNT:   o_rdata <= {15'h0, running, count};
					ADDR_CAPTURE: o_rdata <= {16'h0, capture};
					ADDR_STATUS:  o_rdata <= {29'h0, status};
					ADDR_MASK:    o_rdata <= {29'h0, mask};
					ADDR_DEAD:    o_rdata <= {24'h0, dead};
					default:      o_rdata <= 32'h0;
				endcase
			end
			if (o_rvalid && i_rready) begin
				o_rvalid  <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking dtp_cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	chk_count_down: assert property (tick && !at_zero
		&& !start_ev && !rst_ev |=> count == $past(count) - 16'h0001)
		else $error("count did not decrement");
	chk_never_up: assert property (!start_ev && !rst_ev && !tc_ev
		|=> count <= $past(count))
		else $error("count moved upward");
	chk_reload_tc: assert property (tc_ev
		|=> count == $past(period))
		else $error("no reload at terminal count");
	chk_reset_load: assert property (rst_ev
		|=> count == $past(period) && running)
		else $error("reset input did not reload");
	chk_capture_val: assert property (cap_ev
		|=> capture == $past(count))
		else $error("capture value wrong");
	chk_one_stop: assert property (tc_ev && mode == MODE_ONE
		&& !start_ev && !rst_ev |=> !running)
		else $error("one shot kept running");
	chk_enable_gate: assert property (mode == MODE_ENABLE
		&& !i_ctl.enable && !start_ev && !rst_ev
		|=> count == $past(count))
		else $error("counted without enable");
	chk_kill_low: assert property (i_ctl.kill
		|=> !o_pwm.cmp && !o_pwm.cmp_n)
		else $error("kill did not force outputs low");
	chk_no_overlap: assert property (!(o_pwm.cmp && o_pwm.cmp_n))
		else $error("both phases active");
	chk_cmp_phase: assert property (!i_ctl.kill && dead_done
		|=> o_pwm.cmp != o_pwm.cmp_n)
		else $error("phases not complementary");
	chk_irq_level: assert property (tc_ev && mask[ST_TC]
		&& !wr_mask |=> ##1 o_irq)
		else $error("interrupt not raised");
	chk_irq_quiet: assert property ((status & mask) == 3'b000
		|=> !o_irq)
		else $error("interrupt without unmasked status");
	chk_tc_pulse: assert property (tc_ev |=> o_pwm.tc)
		else $error("terminal count not shown");
	chk_tc_clear: assert property (o_pwm.tc && tick_raw && !tc_ev
		|=> !o_pwm.tc)
		else $error("terminal count held too long");

	cov_tc: cover property (tc_ev);
	cov_cap: cover property (cap_ev);
	cov_kill: cover property (i_ctl.kill && raw_q);
	cov_one: cover property (tc_ev && mode == MODE_ONE);
	cov_free: cover property (tc_ev && mode == MODE_FREE);

endmodule

//--- test/dtp_route_model.sv
// Routing-side model that supplies the counting clock sources.
`timescale 1ns/100ps
module dtp_route_model #(
	parameter int NCLK = 4
) (
	// Clock and reset.
	input  wire logic            i_clk,
	input  wire logic            i_rst,
	// Clock sources toward the timer.
	output logic [NCLK-1:0]      o_clk_src
);
	logic [7:0] div [NCLK];

	// Source k toggles every k+2 cycles, slow enough to be sampled on i_clk.
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < NCLK; k++) begin
			if (i_rst || div[k] == 8'(k + 1)) begin
				div[k] <= 8'h00;
				o_clk_src[k] <= i_rst ? 1'b0 : ~o_clk_src[k];
			end else begin
				div[k] <= div[k] + 8'h01;
			end
		end
	end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the down-count timer and PWM.
`timescale 1ns/100ps
module tb_top;
	import dtp_pkg::*;
	logic         i_clk = 1'b0;
	logic         i_rst = 1'b1;
	dtp_ctl_in_s  ctl = '0;
	logic [3:0]   src;
	dtp_pwm_out_s pwm;
	logic         irq, awrdy, wrdy, ardy, bv, rv;
	logic         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [7:0]   awa = 8'h00, ara = 8'h00;
	logic [31:0]  wd = 32'h0, rdat;
	logic [1:0]   bresp, rresp;
	logic [41:0]  rows [9];
	logic [4:0]   cmp_exp = 5'h0E;
	int           error_cnt = 0, cmp_count = 0;

	always #10 i_clk = ~i_clk;

	dtp_route_model #(.NCLK(4)) src_m (.i_clk(i_clk), .i_rst(i_rst),
		.o_clk_src(src));

	dtp_timer #(.NCLK(4)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_ctl(ctl),
		.i_clk_src(src), .o_pwm(pwm), .o_irq(irq), .i_awaddr(awa),
		.i_awvalid(awv), .o_awready(awrdy), .i_wdata(wd), .i_wstrb(4'hF),
		.i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv),
		.i_bready(br), .i_araddr(ara), .i_arvalid(arv), .o_arready(ardy),
		.o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wrap_up;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic tmo;
		error_cnt++;
		wrap_up();
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge i_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge i_clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (int k = 0; k < 100; k++) begin
			@(posedge i_clk);
			if (awv && awrdy) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (bv) begin
				br <= 1'b0;
				chk(32'(bresp), 32'(e));
				return;
			end
		end
		tmo();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] e);
		@(posedge i_clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (int k = 0; k < 100; k++) begin
			@(posedge i_clk);
			if (arv && ardy) arv <= 1'b0;
			if (rv) begin
				rr <= 1'b0;
				d = rdat;
				e = rresp;
				return;
			end
		end
		tmo();
	endtask

	// Both outputs high together would short a half bridge.
	always @(posedge i_clk) begin
		if (!i_rst && pwm.cmp && pwm.cmp_n) chk(32'h1, 32'h0);
	end

	initial begin
		repeat (50000) @(posedge i_clk);
		tmo();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [1:0]  e;
		int          n;
		rows = '{{ADDR_CTRL, 32'h0, RESP_OKAY},
			{ADDR_PERIOD, 16'h0, RST_PERIOD, RESP_OKAY},
			{ADDR_COMPARE, 16'h0, RST_COMPARE, RESP_OKAY},
			{ADDR_COUNT, 32'h0, RESP_OKAY}, {ADDR_STATUS, 32'h0, RESP_OKAY},
			{ADDR_MASK, 32'h0, RESP_OKAY},
			{ADDR_DEAD, 24'h0, RST_DEAD, RESP_OKAY},
			{8'h20, 32'h0, RESP_SLVERR}, {8'h06, 32'h0, RESP_SLVERR}};
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (rows[i]) begin
			rd(rows[i][41:34], d, e);
			chk(d, rows[i][33:2]);
			chk(32'(e), 32'(rows[i][1:0]));
		end
		wr(ADDR_COUNT, 32'h5, RESP_SLVERR);
		wr(ADDR_PERIOD, 32'h3, RESP_OKAY);
		wr(ADDR_COMPARE, 32'h3, RESP_OKAY);
		wr(ADDR_MASK, 32'h1, RESP_OKAY);
		wr(ADDR_CTRL, 32'h7, RESP_OKAY);
		for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge i_clk);
		if (n == 400) tmo();
		chk(32'(irq), 32'h1);
		chk(32'(pwm.tc), 32'h1);
		cyc(4);
		chk(32'(pwm.tc), 32'h0);
		rd(ADDR_COUNT, d, e);
		chk(d, 32'h3);
		for (n = 0; n < 5; n++) begin
			wr(ADDR_CTRL, 32'h5 | (32'(n) << 4), RESP_OKAY);
			cyc(3);
			chk(32'({pwm.cmp, pwm.cmp_n}), 32'({cmp_exp[n], !cmp_exp[n]}));
		end
		wr(ADDR_DEAD, 32'h5, RESP_OKAY);
		wr(ADDR_CTRL, 32'h35, RESP_OKAY);
		cyc(2);
		chk(32'({pwm.cmp, pwm.cmp_n}), 32'h0);
		cyc(10);
		chk(32'({pwm.cmp, pwm.cmp_n}), 32'h2);
		ctl.kill <= 1'b1;
		cyc(3);
		chk(32'({pwm.cmp, pwm.cmp_n}), 32'h0);
		ctl.kill <= 1'b0;
		ctl.capture <= 1'b1;
		cyc(12);
		chk(32'({pwm.cmp, pwm.cmp_n}), 32'h2);
		ctl.capture <= 1'b0;
		rd(ADDR_CAPTURE, d, e);
		chk(d, 32'h3);
		rd(ADDR_STATUS, d, e);
		chk(32'(d[2]), 32'h1);
		chk(32'(d[1:0]), 32'h3);
		wr(ADDR_STATUS, 32'h7, RESP_OKAY);
		cyc(3);
		chk(32'(irq), 32'h0);
		// Enable-gated mode: the count must hold while enable is low.
		wr(ADDR_PERIOD, 32'h9, RESP_OKAY);
		wr(ADDR_CTRL, 32'h9, RESP_OKAY);
		ctl.reset <= 1'b1;
		cyc(3);
		ctl.reset <= 1'b0;
		cyc(20);
		rd(ADDR_COUNT, d, e);
		chk(32'(d[15:0]), 32'h9);
		ctl.enable <= 1'b1;
		cyc(24);
		ctl.enable <= 1'b0;
		cyc(2);
		rd(ADDR_COUNT, d, e);
		chk(32'(d[15:0] < 16'h9 && d[15:0] > 16'h0), 32'h1);
		ctl.trig <= 1'b1;
		cyc(3);
		ctl.trig <= 1'b0;
		rd(ADDR_COUNT, d, e);
		chk(32'(d[15:0]), 32'h9);
		// Free-running on source three: slower ticks, no stop at zero.
		wr(ADDR_CTRL, 32'h183, RESP_OKAY);
		cyc(45);
		rd(ADDR_COUNT, d, e);
		chk(32'(d[15:0] >= 16'h3 && d[15:0] <= 16'h6), 32'h1);
		cyc(120);
		rd(ADDR_COUNT, d, e);
		chk(32'(d[16]), 32'h1);
		rd(ADDR_STATUS, d, e);
		chk(32'(d[ST_TC]), 32'h1);
		wrap_up();
	end
endmodule
